// [hdl/ee_access_params.svh]
// constants for the nonvolatile access register block
// assumes the cpu register bus presents a 3-bit register select and byte data
//
// Operation
// [RQ1] The data-low register is an 8-bit read/write byte, zero after reset, that carries the EEPROM byte or the low program byte.
// [RQ2] The address-low register is an 8-bit read/write byte, zero after reset, that gives the low eight address bits.
// [RQ3] The data-high register holds six upper program-word bits in bits 5 to 0, and bits 7 and 6 read as zero.
// [RQ4] The address-high register holds upper program address bits in bits 4 to 0, and bits 7 to 5 read as zero.
// [RQ5] No EEPROM write cycle may start while the write-enable bit is zero, and that bit resets to zero; the code starts one if the same write sets it.
// [RQ6] Setting the write-start bit begins an EEPROM write, and a written zero to that bit is ignored.
// [RQ7] The write-start bit reads zero whenever no EEPROM write is in progress.
// [RQ8] Setting the read-start bit starts a read that hardware then clears, and a written zero does nothing.
// [RQ9] The space-select bit sends operations to program memory when one and to data memory when zero, and program memory is only read.
// [RQ10] A write cut short by a master-clear or watchdog reset sets the write-error flag.
// [RQ11] A write starts only after 55h then AAh go to the unlock register, immediately followed by the write-start set with writes enabled.
// [RQ12] When a write completes the write-start bit clears and the write-complete flag sets, and only software clears that flag; the code also clears it on rst.
// [RQ13] The write duration is a configurable cycle count during which the write-start bit stays set.
`ifndef EE_ACCESS_PARAMS_SVH
`define EE_ACCESS_PARAMS_SVH
// register selects
`define SEL_DATA_LOW 3'h0
`define SEL_ADDR_LOW 3'h1
`define SEL_DATA_HIGH 3'h2
`define SEL_ADDR_HIGH 3'h3
`define SEL_CONTROL 3'h4
`define SEL_UNLOCK 3'h5
`define SEL_FLAG 3'h6
// control register bits
`define BIT_SPACE 7
`define BIT_WERR 3
`define BIT_WRITE_ENABLE_BIT 2
`define BIT_WR 1
`define BIT_RD 0
// unlock keys
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
// field masks of the narrow registers
`define MASK_DATA_HIGH 8'h3F
`define MASK_ADDR_HIGH 8'h1F
// self-timed write, in microseconds, and its cycle count at 20 MHz
`define WRITE_TIME_US 5000
`define CLK_MHZ 20
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`endif

// [hdl/ee_access_pkg.sv]
// types for the nonvolatile access register block
// assumes nothing beyond a SystemVerilog compiler
package ee_access_pkg;
  // unlock sequence progress
  typedef enum logic [1:0] {
    unlock_idle,
    unlock_got_first,
    unlock_armed
  } unlock_state_t;
endpackage

// [hdl/ee_write_timer.sv]
// self-timed write duration counter for the EEPROM write cycle
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
module ee_write_timer #(
  parameter int CYCLES = 100000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [31:0] count_reg;

  // count down while busy; done pulses on the last cycle
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      count_reg <= 32'h0;
    end else if (start) begin
      count_reg <= 32'(CYCLES); // see [RQ13]
    end else if (count_reg != 32'h0) begin
      count_reg <= count_reg - 32'h1;
    end
  end

  assign busy = (count_reg != 32'h0);
  assign done = (count_reg == 32'h1);
endmodule // ee_write_timer
`default_nettype wire

// [hdl/ee_access_regs.sv]
// cpu-facing registers for indirect data EEPROM and program flash access
// assumes a single-cycle register port; arrays answer combinationally
`timescale 1ns/1ns
`default_nettype none
`include "ee_access_params.svh"
module ee_access_regs #(
  parameter int WRITE_CYCLES = `WRITE_CYCLES,
  parameter int PROG_ADDR_BITS = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset cause, pulses on the cycle the cpu reset is asserted
  input wire logic external_master_clear,
  input wire logic watchdog_timeout,
  // cpu register port
  input wire logic [2:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // data eeprom array
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  output logic ee_write_start,
  output logic ee_write_active,
  output logic ee_read,
  input wire logic [7:0] ee_rdata,
  // program flash array, read only
  output logic [PROG_ADDR_BITS-1:0] prog_addr,
  output logic prog_read,
  input wire logic [13:0] prog_rdata,
  // write complete event
  output logic write_complete_flag
);
  logic [7:0] data_low_reg;
  logic [7:0] addr_low_reg;
  logic [5:0] data_high_reg;
  logic [4:0] addr_high_reg;
  logic space_select_reg;
  logic write_enable_bit_reg;
  logic write_error_flag_reg;
  logic read_start_reg;
  logic write_start_reg;
  logic flag_reg;
  ee_access_pkg::unlock_state_t unlock_reg;
  logic [7:0] control_view;
  logic wr_ctl;
  logic start_write;
  logic timer_busy;
  logic timer_done;
  logic abort;

  assign wr_ctl = reg_wr && (reg_sel == `SEL_CONTROL);
  // abnormal reset during a write, seen before rst takes effect
  assign abort = (external_master_clear || watchdog_timeout) && write_start_reg;
  // a write needs the key pair, writes enabled, data space and no write busy
  assign start_write = wr_ctl && reg_wdata[`BIT_WR] && !write_start_reg
    && (unlock_reg == ee_access_pkg::unlock_armed) // see [RQ11]
    && (reg_wdata[`BIT_WRITE_ENABLE_BIT] || write_enable_bit_reg) // see [RQ5]
    && !space_select_reg && !reg_wdata[`BIT_SPACE]; // see [RQ9]

  // unlock sequencer: any other register write breaks the chain
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_reg <= ee_access_pkg::unlock_idle;
    end else if (reg_wr && reg_sel == `SEL_UNLOCK) begin
      unique case (unlock_reg)
        ee_access_pkg::unlock_idle:
          unlock_reg <= (reg_wdata == `KEY_FIRST) ?
            ee_access_pkg::unlock_got_first : ee_access_pkg::unlock_idle;
        ee_access_pkg::unlock_got_first:
          unlock_reg <= (reg_wdata == `KEY_SECOND) ?
            ee_access_pkg::unlock_armed : ee_access_pkg::unlock_idle;
        ee_access_pkg::unlock_armed:
          unlock_reg <= (reg_wdata == `KEY_FIRST) ?
            ee_access_pkg::unlock_got_first : ee_access_pkg::unlock_idle;
      endcase
    end else if (reg_wr) begin
      unlock_reg <= ee_access_pkg::unlock_idle; // see [RQ11]
    end
  end

  // address registers
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_low_reg <= 8'h00;
      addr_high_reg <= 5'h00;
    end else if (reg_wr && reg_sel == `SEL_ADDR_LOW) begin
      addr_low_reg <= reg_wdata; // see [RQ2]
    end else if (reg_wr && reg_sel == `SEL_ADDR_HIGH) begin
      addr_high_reg <= reg_wdata[4:0]; // see [RQ4]
    end
  end

  // data registers: cpu write, or loaded by a completed read
  always_ff @(posedge clk) begin
    if (rst) begin
      data_low_reg <= 8'h00;
      data_high_reg <= 6'h00;
    end else if (read_start_reg && space_select_reg) begin
      data_low_reg <= prog_rdata[7:0]; // see [RQ1]
      data_high_reg <= prog_rdata[13:8]; // see [RQ3]
    end else if (read_start_reg) begin
      data_low_reg <= ee_rdata; // see [RQ1]
    end else if (reg_wr && reg_sel == `SEL_DATA_LOW && !write_start_reg) begin
      data_low_reg <= reg_wdata; // see [RQ1]
    end else if (reg_wr && reg_sel == `SEL_DATA_HIGH) begin
      data_high_reg <= reg_wdata[5:0]; // see [RQ3]
    end
  end

  // plain control bits; write-enable does not affect a running write
  always_ff @(posedge clk) begin
    if (rst) begin
      space_select_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0; // see [RQ5]
    end else if (wr_ctl) begin
      space_select_reg <= reg_wdata[`BIT_SPACE]; // see [RQ9]
      write_enable_bit_reg <= reg_wdata[`BIT_WRITE_ENABLE_BIT];
    end
  end

  // error flag: rst leaves it alone so it outlives the reset it reports;
  // its power-up value is unknown until software writes it
  always_ff @(posedge clk) begin
    if (abort) begin
      write_error_flag_reg <= 1'b1; // see [RQ10]
    end else if (wr_ctl && !rst) begin
      write_error_flag_reg <= reg_wdata[`BIT_WERR];
    end
  end

  // read start: set only, held one cycle while the array answers
  always_ff @(posedge clk) begin
    if (rst) begin
      read_start_reg <= 1'b0;
    end else if (read_start_reg) begin
      read_start_reg <= 1'b0; // see [RQ8]
    end else if (wr_ctl && reg_wdata[`BIT_RD]) begin
      read_start_reg <= 1'b1; // see [RQ8]
    end
  end

  // write start: zero writes ignored, cleared at completion or on an abort
  always_ff @(posedge clk) begin
    if (rst) begin
      write_start_reg <= 1'b0;
    end else if (start_write) begin
      write_start_reg <= 1'b1; // see [RQ6]
    end else if (timer_done || abort) begin
      // an abort also stops the timer, so nothing else would clear it
      write_start_reg <= 1'b0; // see [RQ7] [RQ12]
    end
  end

  // completion flag: set wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (write_start_reg && timer_done) begin
      flag_reg <= 1'b1; // see [RQ12]
    end else if (reg_wr && reg_sel == `SEL_FLAG && !reg_wdata[0]) begin
      flag_reg <= 1'b0;
    end
  end

  ee_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(start_write),
    .abort(abort),
    .busy(timer_busy),
    .done(timer_done)
  );

  // read mux; unlock register reads zero, unused bits zero
  assign control_view = {space_select_reg, 3'b000, write_error_flag_reg,
    write_enable_bit_reg, write_start_reg, read_start_reg};
  always_comb begin
    unique case (reg_sel)
      `SEL_DATA_LOW: reg_rdata = data_low_reg;
      `SEL_ADDR_LOW: reg_rdata = addr_low_reg;
      `SEL_DATA_HIGH: reg_rdata = {2'b00, data_high_reg}; // see [RQ3]
      `SEL_ADDR_HIGH: reg_rdata = {3'b000, addr_high_reg}; // see [RQ4]
      `SEL_CONTROL: reg_rdata = control_view;
      `SEL_FLAG: reg_rdata = {7'h00, flag_reg};
      default: reg_rdata = 8'h00;
    endcase
  end

  // array side
  assign ee_addr = addr_low_reg;
  assign ee_wdata = data_low_reg;
  assign ee_write_start = start_write;
  assign ee_write_active = write_start_reg;
  assign ee_read = read_start_reg && !space_select_reg;
  assign prog_read = read_start_reg && space_select_reg;
  assign prog_addr = PROG_ADDR_BITS'({addr_high_reg, addr_low_reg});
  assign write_complete_flag = flag_reg;

  // a write never starts without the unlock pair
  a_write_needs_key: assert property ( // see [RQ11]
    @(posedge clk) disable iff (rst)
    $rose(write_start_reg) |->
      $past(unlock_reg) == ee_access_pkg::unlock_armed)
    else $error("write started without unlock");
  a_write_needs_en: assert property ( // see [RQ5]
    @(posedge clk) disable iff (rst)
    $rose(write_start_reg) |-> $past(reg_wdata[`BIT_WRITE_ENABLE_BIT])
      || $past(write_enable_bit_reg))
    else $error("write started while disabled");
  a_zero_keeps_wr: assert property ( // see [RQ6]
    @(posedge clk) disable iff (rst)
    write_start_reg && !timer_done && !abort |=> write_start_reg)
    else $error("write start dropped early");
  a_wr_tracks_busy: assert property ( // see [RQ7] [RQ13]
    @(posedge clk) disable iff (rst)
    write_start_reg == timer_busy)
    else $error("write start and timer disagree");
  a_read_one_cycle: assert property ( // see [RQ8]
    @(posedge clk) disable iff (rst)
    read_start_reg |=> !read_start_reg)
    else $error("read start held too long");
  a_read_loads: assert property ( // see [RQ1]
    @(posedge clk) disable iff (rst)
    read_start_reg && !space_select_reg |=> data_low_reg == $past(ee_rdata))
    else $error("read data not loaded");
  a_no_prog_write: assert property ( // see [RQ9]
    @(posedge clk) disable iff (rst)
    space_select_reg |-> !start_write)
    else $error("write to program space");
  a_done_sets_flag: assert property ( // see [RQ12]
    @(posedge clk) disable iff (rst)
    write_start_reg && timer_done |=> flag_reg && !write_start_reg)
    else $error("completion not flagged");
  a_abort_errs: assert property ( // see [RQ10]
    @(posedge clk)
    abort |=> write_error_flag_reg && !write_start_reg)
    else $error("aborted write not flagged");
endmodule // ee_access_regs
`default_nettype wire

// [verif/ee_array_model.sv]
// behavioural data eeprom and program flash arrays behind the access block
// assumes one core clock; both arrays answer combinationally
`timescale 1ns/1ns
`default_nettype none
module ee_array_model (
  // clock
  input wire logic clk,
  // data eeprom side
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_wdata,
  input wire logic ee_write_start,
  input wire logic ee_read,
  output logic [7:0] ee_rdata,
  // program flash side
  input wire logic [12:0] prog_addr,
  input wire logic prog_read,
  output logic [13:0] prog_rdata
);
  logic [7:0] mem [256];

  // blank array at power-up
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
  end

  // stored at the accepting edge; byte write erases and programs at once
  always @(posedge clk) begin
    if (ee_write_start) begin
      mem[ee_addr] <= ee_wdata;
    end
  end

  // outside a strobe the bus shows the inverse, so a late sample fails
  assign ee_rdata = ee_read ? mem[ee_addr] : ~mem[ee_addr];
  // program word is a fixed function of its address
  assign prog_rdata = prog_read ? {1'b1, prog_addr} : ~{1'b1, prog_addr};
endmodule // ee_array_model
`default_nettype wire

// [verif/ee_access_regs_bench.sv]
// self-checking bench for the nonvolatile access register block
// assumes the array model answers combinationally; write time shortened
`timescale 1ns/1ns
`default_nettype none
module ee_access_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic external_master_clear = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, ee_addr, ee_wdata, ee_rdata;
  logic ee_write_start, ee_write_active, ee_read, prog_read;
  logic write_complete_flag;
  logic [12:0] prog_addr;
  logic [13:0] prog_rdata;
  int error_cnt = 0;
  int cmp_count = 0;
  int i;
  // shortened write time, shared by the instance and the expectations
  localparam int WR_CYC = 8;

  // 50 ns core clock
  always #25 clk = ~clk;

  ee_access_regs #(.WRITE_CYCLES(WR_CYC)) u_ee_access_regs (
    .clk, .rst, .external_master_clear, .watchdog_timeout, .reg_sel,
    .reg_wr, .reg_rd(1'b0), .reg_wdata, .reg_rdata, .ee_addr, .ee_wdata,
    .ee_write_start, .ee_write_active, .ee_read, .ee_rdata, .prog_addr,
    .prog_read, .prog_rdata, .write_complete_flag);

  ee_array_model u_ee_array_model (
    .clk, .ee_addr, .ee_wdata, .ee_write_start, .ee_read, .ee_rdata,
    .prog_addr, .prog_read, .prog_rdata);

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe stays up so back-to-back writes never reassign it in one step
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
  endtask

  // read data is combinational; sampled 10 ns after the edge, where it has settled
  task automatic chk(input logic [2:0] s, input logic [7:0] m,
                     input logic [7:0] e);
    reg_sel <= s;
    reg_wr <= 1'b0;
    #10;
    cmp8(reg_rdata & m, e);
    @(posedge clk);
  endtask

  // key pair then the control byte, on three back-to-back edges
  task automatic unlock(input logic [7:0] c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c);
  endtask

  // poll the write-start bit; exp_n is the number of edges still to wait
  task automatic wait_idle(input int exp_n);
    int n;
    n = 0;
    reg_sel <= 3'h4;
    reg_wr <= 1'b0;
    #10;
    cmp8({7'h00, ee_write_active}, 8'h01);
    while (reg_rdata[1] !== 1'b0 && n < 40) begin
      @(posedge clk);
      #10;
      n++;
    end
    cmp8(8'(n), 8'(exp_n));
    cmp8({6'h00, ee_write_active, write_complete_flag}, 8'h01);
    if (n >= 40) begin
      report_and_stop();
    end
    @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // error flag powers up unknown and survives reset, so it is masked
    for (i = 0; i < 5; i++) begin
      chk(3'(i), (i == 4) ? 8'hF7 : 8'hFF, 8'h00);
    end
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'hFF);
    wr(3'h3, 8'hFF);
    chk(3'h0, 8'hFF, 8'hFF);
    chk(3'h1, 8'hFF, 8'hFF);
    chk(3'h2, 8'hFF, 8'h3F);
    chk(3'h3, 8'hFF, 8'h1F);
    // no key pair: only the enable bit sticks; key pair without the enable bit starts nothing
    wr(3'h4, 8'h06);
    chk(3'h4, 8'hF7, 8'h04);
    wr(3'h4, 8'h00);
    unlock(8'h02);
    chk(3'h4, 8'hF7, 8'h00);
    // keys in the wrong order
    wr(3'h5, 8'hAA);
    wr(3'h5, 8'h55);
    wr(3'h4, 8'h06);
    chk(3'h4, 8'hF7, 8'h04);
    // another register write between the keys breaks the chain
    wr(3'h1, 8'h12);
    wr(3'h5, 8'h55);
    wr(3'h0, 8'h3C);
    wr(3'h5, 8'hAA);
    wr(3'h4, 8'h06);
    chk(3'h4, 8'hF7, 8'h04);
    // proper sequence: the write runs, a zero to the start bit is ignored
    unlock(8'h06);
    chk(3'h4, 8'hF7, 8'h06);
    wr(3'h4, 8'h04);
    chk(3'h4, 8'hF7, 8'h06);
    // three edges of the write have passed since the start edge
    wait_idle(WR_CYC - 3);
    chk(3'h6, 8'h01, 8'h01);
    wr(3'h6, 8'h00);
    chk(3'h6, 8'h01, 8'h00);
    // data read returns the byte just written
    wr(3'h4, 8'h01);
    chk(3'h4, 8'hF7, 8'h01);
    chk(3'h0, 8'hFF, 8'h3C);
    chk(3'h4, 8'hF7, 8'h00);
    // program read fills both data bytes
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h45);
    wr(3'h4, 8'h81);
    chk(3'h4, 8'hF7, 8'h81);
    chk(3'h0, 8'hFF, 8'h45);
    chk(3'h2, 8'hFF, 8'h23);
    unlock(8'h86);
    chk(3'h4, 8'hF7, 8'h84);
    // cut a running write short by each reset cause in turn
    for (i = 0; i < 2; i++) begin
      wr(3'h4, 8'h04);
      unlock(8'h06);
      reg_wr <= 1'b0;
      external_master_clear <= (i == 0);
      watchdog_timeout <= (i == 1);
      rst <= 1'b1;
      @(posedge clk);
      external_master_clear <= 1'b0;
      watchdog_timeout <= 1'b0;
      @(posedge clk);
      rst <= 1'b0;
      chk(3'h4, 8'hFF, 8'h08);
    end
    report_and_stop();
  end
endmodule // ee_access_regs_bench
`default_nettype wire
